// File: verilog/mtf_top.sv
// MPC training command decoder, training FIFO and calibration pattern
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
module mtf_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cke,
   input wire logic pd_entry,
   input wire mtf_pkg::mtf_cmd_s cmd,
   input wire mtf_pkg::mtf_beat_s wr_beat_in,
   output mtf_pkg::mtf_beat_s rd_beat_out,
   output logic dq_oe_n,
   output logic dmi_oe_n,
   output logic osc_run,
   output logic zq_begin,
   output logic zq_apply
);
   logic [7:0] first_pattern_byte_q;
   logic [7:0] second_pattern_byte_q;
   logic [7:0] invert_mask_low_byte_q;
   logic [7:0] invert_mask_high_byte_q;
   logic [7:0] mode_q;
   logic [5:0] rl_q;
   logic [5:0] wl_q;
   logic err_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   mtf_pkg::mtf_state_e state_q;
   mtf_pkg::mtf_op_e op_q;
   logic [5:0] lat_q;
   logic [3:0] beat_q;
   logic osc_run_q;
   logic zq_begin_q;
   logic zq_apply_q;
   mtf_pkg::mtf_beat_s out_q;
   logic dq_oe_n_q;
   logic dmi_oe_n_q;
   logic setup;
   logic wr_acc;
   logic mapped;
   logic mpc;
   logic train_mpc;
   logic cas2_ok;
   logic abandon;
   logic err_set;
   logic fifo_wr;
   logic fifo_rd_last;
   logic last_beat;
   logic pat_bit;
   logic dmi_en;
   logic [15:0] mask;
   logic [15:0] cal_dq;
   mtf_pkg::mtf_beat_s fifo_rd;
   logic [2:0] wr_ptr;
   logic [2:0] rd_ptr;

   // APB decode, zero wait states
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign mapped = (paddr == mtf_pkg::REG_PATTERN) || (paddr == mtf_pkg::REG_INVERT) ||
                   (paddr == mtf_pkg::REG_MODE) || (paddr == mtf_pkg::REG_LAT) ||
                   (paddr == mtf_pkg::REG_STAT);
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= !mapped;
         prdata_q <= 32'h0;
         if (!pwrite) begin
            case (paddr)
               mtf_pkg::REG_PATTERN: prdata_q <= {16'h0, second_pattern_byte_q, first_pattern_byte_q};
               mtf_pkg::REG_INVERT: prdata_q <= {16'h0, invert_mask_high_byte_q, invert_mask_low_byte_q};
               mtf_pkg::REG_MODE: prdata_q <= {24'h0, mode_q};
               mtf_pkg::REG_LAT: prdata_q <= {18'h0, wl_q, 2'h0, rl_q};
               mtf_pkg::REG_STAT: prdata_q <= {21'h0, err_q, state_q != mtf_pkg::ST_IDLE, osc_run_q,
                                               1'b0, rd_ptr, 1'b0, wr_ptr};
               default: prdata_q <= 32'h0;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // Pattern and mask bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_pattern_byte_q <= mtf_pkg::FIRST_PAT_RST;
         second_pattern_byte_q <= mtf_pkg::SECOND_PAT_RST;
         invert_mask_low_byte_q <= mtf_pkg::MASK_RST;
         invert_mask_high_byte_q <= mtf_pkg::MASK_RST;
      end else if (wr_acc && paddr == mtf_pkg::REG_PATTERN) begin
         first_pattern_byte_q <= pwdata[7:0];
         second_pattern_byte_q <= pwdata[15:8];
      end else if (wr_acc && paddr == mtf_pkg::REG_INVERT) begin
         invert_mask_low_byte_q <= pwdata[7:0];
         invert_mask_high_byte_q <= pwdata[15:8];
      end
   end

   // Mode and latency settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= mtf_pkg::MODE_RST;
         rl_q <= mtf_pkg::RL_RST;
         wl_q <= mtf_pkg::WL_RST;
      end else if (wr_acc && paddr == mtf_pkg::REG_MODE) begin
         mode_q <= pwdata[7:0];
      end else if (wr_acc && paddr == mtf_pkg::REG_LAT) begin
         rl_q <= pwdata[mtf_pkg::LAT_RL_LSB +: 6];
         wl_q <= pwdata[mtf_pkg::LAT_WL_LSB +: 6];
      end
   end

   // Sticky protocol error; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (err_set) begin
         err_q <= 1'b1;
      end else if (wr_acc && paddr == mtf_pkg::REG_STAT && pwdata[mtf_pkg::STAT_ERR]) begin
         err_q <= 1'b0;
      end
   end

   // Command decode; cke low blocks all MPCs
   assign mpc = cmd.kind == mtf_pkg::KIND_MPC && cke;
   assign train_mpc = mpc && cmd.operand[6] &&
                      (cmd.operand == mtf_pkg::OPC_RD_FIFO || cmd.operand == mtf_pkg::OPC_WR_FIFO ||
                       cmd.operand == mtf_pkg::OPC_CAL_RD);
   assign cas2_ok = cmd.kind == mtf_pkg::KIND_CAS2 && cmd.operand == 7'h0;
   assign abandon = state_q == mtf_pkg::ST_NEED_CAS2 && cmd.kind != mtf_pkg::KIND_NONE && !cas2_ok;
   assign err_set = abandon || (train_mpc && state_q != mtf_pkg::ST_IDLE);
   assign last_beat = beat_q == 4'(mtf_pkg::BURST_BEATS - 1);

   // Training sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= mtf_pkg::ST_IDLE;
         op_q <= mtf_pkg::OP_WR_FIFO;
         lat_q <= 6'h0;
         beat_q <= 4'h0;
      end else begin
         case (state_q)
            mtf_pkg::ST_IDLE: begin
               if (train_mpc) begin
                  state_q <= mtf_pkg::ST_NEED_CAS2;
                  case (cmd.operand)
                     mtf_pkg::OPC_RD_FIFO: op_q <= mtf_pkg::OP_RD_FIFO;
                     mtf_pkg::OPC_CAL_RD: op_q <= mtf_pkg::OP_CAL_RD;
                     default: op_q <= mtf_pkg::OP_WR_FIFO;
                  endcase
               end
            end
            mtf_pkg::ST_NEED_CAS2: begin
               if (cas2_ok) begin
                  // Count starts at the CAS-2 second edge
                  state_q <= mtf_pkg::ST_LATENCY;
                  lat_q <= (op_q == mtf_pkg::OP_WR_FIFO) ? wl_q : rl_q;
               end else if (abandon) begin
                  state_q <= mtf_pkg::ST_IDLE;
               end
            end
            mtf_pkg::ST_LATENCY: begin
               if (lat_q <= 6'h1) begin
                  state_q <= mtf_pkg::ST_BURST;
                  beat_q <= 4'h0;
               end else begin
                  lat_q <= lat_q - 6'h1;
               end
            end
            mtf_pkg::ST_BURST: begin
               // Fixed sixteen beats, burst length field unused
               beat_q <= beat_q + 4'h1;
               if (last_beat) begin
                  state_q <= mtf_pkg::ST_IDLE;
               end
            end
            default: state_q <= mtf_pkg::ST_IDLE;
         endcase
      end
   end

   // Oscillator and impedance calibration; reserved codes fall through
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_run_q <= 1'b0;
         zq_begin_q <= 1'b0;
         zq_apply_q <= 1'b0;
      end else begin
         zq_begin_q <= mpc && cmd.operand == mtf_pkg::OPC_ZQ_BEGIN;
         zq_apply_q <= mpc && cmd.operand == mtf_pkg::OPC_ZQ_APPLY;
         if (mpc && cmd.operand == mtf_pkg::OPC_OSC_ON) begin
            osc_run_q <= 1'b1;
         end else if (mpc && cmd.operand == mtf_pkg::OPC_OSC_OFF) begin
            osc_run_q <= 1'b0;
         end
      end
   end

   assign osc_run = osc_run_q;
   assign zq_begin = zq_begin_q;
   assign zq_apply = zq_apply_q;

   // Training FIFO
   assign fifo_wr = state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_WR_FIFO;
   assign fifo_rd_last = state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_RD_FIFO && last_beat;

   mtf_train_fifo #(
      .DEPTH(mtf_pkg::FIFO_ENTRIES),
      .BEATS(mtf_pkg::BURST_BEATS)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .ptr_clr(pd_entry),
      .wr_en(fifo_wr),
      .wr_last(last_beat),
      .wr_beat(beat_q),
      .wr_data(wr_beat_in),
      .rd_last(fifo_rd_last),
      .rd_beat(beat_q),
      .rd_data(fifo_rd),
      .wr_ptr(wr_ptr),
      .rd_ptr(rd_ptr)
   );

   // Calibration pattern, low bit first, per-pin inversion on DQ only
   assign pat_bit = beat_q[3] ? second_pattern_byte_q[beat_q[2:0]] : first_pattern_byte_q[beat_q[2:0]];
   assign mask = {invert_mask_high_byte_q, invert_mask_low_byte_q};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_cal
         assign cal_dq[gi] = pat_bit ^ mask[gi];
      end
   endgenerate

   assign dmi_en = mode_q[mtf_pkg::MODE_WDBI] || mode_q[mtf_pkg::MODE_RDBI] || !mode_q[mtf_pkg::MODE_DM_DIS];

   // Read data pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '0;
         dq_oe_n_q <= 1'b1;
         dmi_oe_n_q <= 1'b1;
      end else if (state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_CAL_RD) begin
         out_q <= {{2{pat_bit}}, cal_dq};
         dq_oe_n_q <= 1'b0;
         dmi_oe_n_q <= 1'b0;
      end else if (state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_RD_FIFO) begin
         out_q <= fifo_rd;
         dq_oe_n_q <= 1'b0;
         dmi_oe_n_q <= !dmi_en;
      end else begin
         out_q <= '0;
         dq_oe_n_q <= 1'b1;
         dmi_oe_n_q <= 1'b1;
      end
   end

   assign rd_beat_out = out_q;
   assign dq_oe_n = dq_oe_n_q;
   assign dmi_oe_n = dmi_oe_n_q;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_nop_no_action: assert property (
      mpc && !cmd.operand[6] && state_q == mtf_pkg::ST_IDLE |=> state_q == mtf_pkg::ST_IDLE && $stable(osc_run_q))
      else $error("nop changed state");
   a_rd_fifo_decode: assert property (
      state_q == mtf_pkg::ST_IDLE && mpc && cmd.operand == mtf_pkg::OPC_RD_FIFO
      |=> state_q == mtf_pkg::ST_NEED_CAS2 && op_q == mtf_pkg::OP_RD_FIFO)
      else $error("fifo read not decoded");
   a_cal_decode: assert property (
      state_q == mtf_pkg::ST_IDLE && mpc && cmd.operand == mtf_pkg::OPC_CAL_RD |=> op_q == mtf_pkg::OP_CAL_RD)
      else $error("calibration read not decoded");
   a_osc_start: assert property (
      mpc && cmd.operand == mtf_pkg::OPC_OSC_ON |=> osc_run && $stable(state_q))
      else $error("oscillator not started");
   a_zq_pulse: assert property (
      mpc && cmd.operand == mtf_pkg::OPC_ZQ_APPLY |=> zq_apply && !zq_begin)
      else $error("apply pulse missing");
   a_burst_length: assert property (
      $rose(state_q == mtf_pkg::ST_BURST) |-> ##15 (last_beat && state_q == mtf_pkg::ST_BURST) ##1
      state_q == mtf_pkg::ST_IDLE)
      else $error("burst not sixteen beats");
   a_wptr_wrap: assert property (
      fifo_wr && last_beat && !pd_entry |=> wr_ptr == (($past(wr_ptr) == 3'h4) ? 3'h0 : $past(wr_ptr) + 3'h1))
      else $error("write pointer step wrong");
   a_ptr_clear: assert property (
      pd_entry |=> wr_ptr == 3'h0 && rd_ptr == 3'h0)
      else $error("pointers not cleared");
   a_cal_mask_pins: assert property (
      state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_CAL_RD
      |=> !dmi_oe_n && rd_beat_out.dmi == {2{$past(pat_bit)}})
      else $error("mask pins wrong in calibration");
   a_dmi_gate: assert property (
      state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_RD_FIFO && !dmi_en |=> dmi_oe_n && !dq_oe_n)
      else $error("mask pins driven while disabled");
   a_reserved_idle: assert property (
      state_q == mtf_pkg::ST_IDLE && mpc && cmd.operand == 7'h45 |=> state_q == mtf_pkg::ST_IDLE)
      else $error("reserved code acted");

   c_fifo_write: cover property (fifo_wr && last_beat);
   c_fifo_read: cover property (fifo_rd_last);
   c_cal_read: cover property (state_q == mtf_pkg::ST_BURST && op_q == mtf_pkg::OP_CAL_RD && last_beat);
   c_abandon: cover property (abandon);
endmodule

// File: verilog/mtf_pkg.sv
// Constants and types shared by the MPC training block
package mtf_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_PATTERN = 8'h00;
   localparam logic [7:0] REG_INVERT = 8'h04;
   localparam logic [7:0] REG_MODE = 8'h08;
   localparam logic [7:0] REG_LAT = 8'h0c;
   localparam logic [7:0] REG_STAT = 8'h10;
   // Reset values
   localparam logic [7:0] FIRST_PAT_RST = 8'h5a;
   localparam logic [7:0] SECOND_PAT_RST = 8'h3c;
   localparam logic [7:0] MASK_RST = 8'h55;
   localparam logic [7:0] MODE_RST = 8'h80;
   localparam logic [5:0] RL_RST = 6'h06;
   localparam logic [5:0] WL_RST = 6'h04;
   // Mode register fields
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_ODT_LSB = 2;
   localparam int MODE_WDBI = 5;
   localparam int MODE_RDBI = 6;
   localparam int MODE_DM_DIS = 7;
   // Latency register fields
   localparam int LAT_RL_LSB = 0;
   localparam int LAT_WL_LSB = 8;
   // Status register fields
   localparam int STAT_WPTR_LSB = 0;
   localparam int STAT_RPTR_LSB = 4;
   localparam int STAT_OSC = 8;
   localparam int STAT_BUSY = 9;
   localparam int STAT_ERR = 10;
   // Multipurpose operand codes
   localparam logic [6:0] OPC_RD_FIFO = 7'h41;
   localparam logic [6:0] OPC_CAL_RD = 7'h43;
   localparam logic [6:0] OPC_WR_FIFO = 7'h47;
   localparam logic [6:0] OPC_OSC_ON = 7'h4b;
   localparam logic [6:0] OPC_OSC_OFF = 7'h4d;
   localparam logic [6:0] OPC_ZQ_BEGIN = 7'h4f;
   localparam logic [6:0] OPC_ZQ_APPLY = 7'h51;
   // Training burst and FIFO sizes
   localparam int BURST_BEATS = 16;
   localparam int FIFO_ENTRIES = 5;

   typedef enum logic [1:0] {KIND_NONE, KIND_MPC, KIND_CAS2, KIND_OTHER} mtf_kind_e;
   typedef enum logic [1:0] {ST_IDLE, ST_NEED_CAS2, ST_LATENCY, ST_BURST} mtf_state_e;
   typedef enum logic [1:0] {OP_WR_FIFO, OP_RD_FIFO, OP_CAL_RD} mtf_op_e;

   typedef struct packed {
      mtf_kind_e kind;
      logic [6:0] operand;
   } mtf_cmd_s;

   typedef struct packed {
      logic [1:0] dmi;
      logic [15:0] dq;
   } mtf_beat_s;
endpackage

// File: verilog/mtf_train_fifo.sv
// Training FIFO storage with wrapping write and read pointers
`timescale 1ns/10ps
module mtf_train_fifo #(
   parameter int DEPTH = mtf_pkg::FIFO_ENTRIES,
   parameter int BEATS = mtf_pkg::BURST_BEATS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ptr_clr,
   input wire logic wr_en,
   input wire logic wr_last,
   input wire logic [$clog2(BEATS)-1:0] wr_beat,
   input wire mtf_pkg::mtf_beat_s wr_data,
   input wire logic rd_last,
   input wire logic [$clog2(BEATS)-1:0] rd_beat,
   output mtf_pkg::mtf_beat_s rd_data,
   output logic [2:0] wr_ptr,
   output logic [2:0] rd_ptr
);
   mtf_pkg::mtf_beat_s mem [DEPTH][BEATS];
   logic [2:0] wr_ptr_q;
   logic [2:0] rd_ptr_q;

   // Unwritten entries hold whatever is there
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_ptr_q][wr_beat] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= 3'h0;
      end else if (ptr_clr) begin
         wr_ptr_q <= 3'h0;
      end else if (wr_en && wr_last) begin
         wr_ptr_q <= (wr_ptr_q == 3'(DEPTH - 1)) ? 3'h0 : wr_ptr_q + 3'h1;
      end
   end

   // Reads leave the contents intact
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ptr_q <= 3'h0;
      end else if (ptr_clr) begin
         rd_ptr_q <= 3'h0;
      end else if (rd_last) begin
         rd_ptr_q <= (rd_ptr_q == 3'(DEPTH - 1)) ? 3'h0 : rd_ptr_q + 3'h1;
      end
   end

   assign rd_data = mem[rd_ptr_q][rd_beat];
   assign wr_ptr = wr_ptr_q;
   assign rd_ptr = rd_ptr_q;
endmodule

// File: verif/mtf_ctrl_model.sv
// Memory controller model issuing training commands and write bursts
`timescale 1ns/10ps
module mtf_ctrl_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic bad,
   input wire logic [6:0] opcode,
   input wire logic [15:0] seed,
   input wire logic [5:0] lat,
   output mtf_pkg::mtf_cmd_s cmd,
   output mtf_pkg::mtf_beat_s wr_beat_in,
   output logic cas_seen,
   output logic busy
);
   logic [1:0] st_q;
   int cnt_q;
   int leff;
   logic needs_cas;

   assign leff = (lat == 6'h00) ? 1 : int'(lat);
   assign needs_cas = opcode inside {mtf_pkg::OPC_RD_FIFO, mtf_pkg::OPC_CAL_RD, mtf_pkg::OPC_WR_FIFO};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= 2'h0;
         cnt_q <= 0;
         cmd <= '0;
         cas_seen <= 1'b0;
         busy <= 1'b0;
         wr_beat_in <= '1;
      end else begin
         cas_seen <= 1'b0;
         // Data lines keep changing outside a burst
         wr_beat_in <= ~wr_beat_in;
         case (st_q)
            2'h0: begin
               if (go) begin
                  cmd <= '{mtf_pkg::KIND_MPC, opcode};
                  busy <= 1'b1;
                  st_q <= 2'h1;
               end
            end
            2'h1: begin
               cmd <= '0;
               if (needs_cas) begin
                  cmd <= '{bad ? mtf_pkg::KIND_OTHER : mtf_pkg::KIND_CAS2, 7'h00};
                  st_q <= 2'h2;
               end else begin
                  busy <= 1'b0;
                  st_q <= 2'h0;
               end
            end
            2'h2: begin
               cmd <= '0;
               cas_seen <= !bad;
               cnt_q <= 1;
               busy <= !bad;
               st_q <= bad ? 2'h0 : 2'h3;
            end
            default: begin
               cnt_q <= cnt_q + 1;
               if (opcode == mtf_pkg::OPC_WR_FIFO && cnt_q >= leff && cnt_q < leff + 16)
                  wr_beat_in <= {2'(cnt_q - leff), seed + 16'(cnt_q - leff)};
               if (cnt_q == leff + 17) begin
                  busy <= 1'b0;
                  st_q <= 2'h0;
               end
            end
         endcase
      end
   end
endmodule

// File: verif/mtf_top_test.sv
// Self-checking bench for the MPC training block
`timescale 1ns/10ps
module mtf_top_test;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} mtf_row_s;
   logic pclk, presetn, psel, penable, pwrite, cke, pd_entry, go, bad, rerr, dmi_on;
   logic pready, pslverr, dq_oe_n, dmi_oe_n, osc_run, zq_begin, zq_apply, cas_seen, busy;
   logic [7:0] paddr, p0, p1, m0, m1;
   logic [31:0] pwdata, prdata, rdv;
   logic [6:0] opcode;
   logic [15:0] seed;
   logic [5:0] lat;
   mtf_pkg::mtf_cmd_s cmd;
   mtf_pkg::mtf_beat_s wr_beat_in, rd_beat_out;
   int n_fail, samples_checked, cyc, zq_b, zq_a;
   logic [6:0] codes [5] = '{7'h3f, 7'h00, 7'h45, 7'h49, 7'h7f};
   mtf_row_s rows [6] = '{
      '{mtf_pkg::REG_PATTERN, {16'h0, mtf_pkg::SECOND_PAT_RST, mtf_pkg::FIRST_PAT_RST}, 1'b0},
      '{mtf_pkg::REG_INVERT, {16'h0, mtf_pkg::MASK_RST, mtf_pkg::MASK_RST}, 1'b0},
      '{mtf_pkg::REG_MODE, {24'h0, mtf_pkg::MODE_RST}, 1'b0},
      '{mtf_pkg::REG_LAT, {18'h0, mtf_pkg::WL_RST, 2'h0, mtf_pkg::RL_RST}, 1'b0},
      '{mtf_pkg::REG_STAT, 32'h0, 1'b0},
      '{8'h14, 32'h0, 1'b1}};

   mtf_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cke, .pd_entry, .cmd, .wr_beat_in, .rd_beat_out, .dq_oe_n, .dmi_oe_n, .osc_run, .zq_begin, .zq_apply);
   mtf_ctrl_model u_ctrl (.pclk, .presetn, .go, .bad, .opcode, .seed, .lat, .cmd, .wr_beat_in, .cas_seen, .busy);

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Pulses counted mid-cycle, clear of the bench's own edge
   always @(negedge pclk) begin
      if (zq_begin === 1'b1)
         zq_b++;
      if (zq_apply === 1'b1)
         zq_a++;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic mtf_pkg::mtf_beat_s exp_beat(input logic [6:0] op, input logic [15:0] sd, input int b);
      logic bt;
      bt = (b < 8) ? p0[b[2:0]] : p1[b[2:0]];
      if (op == mtf_pkg::OPC_CAL_RD)
         return {{bt, bt}, {8{bt}} ^ m1, {8{bt}} ^ m0};
      return {b[1:0], sd + 16'(b)};
   endfunction

   // One command through the controller model, checking any read burst
   task automatic run(input logic [6:0] op, input logic [15:0] sd, input int lt, input logic bd);
      int k;
      int nb;
      int w;
      logic full;
      mtf_pkg::mtf_beat_s e;
      k = 0;
      nb = 0;
      full = (op == mtf_pkg::OPC_CAL_RD) || dmi_on;
      @(posedge pclk);
      opcode <= op;
      seed <= sd;
      lat <= 6'(lt);
      bad <= bd;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      for (w = 0; w < 80 && (w < 2 || busy === 1'b1); w++) begin
         @(posedge pclk);
         if (cas_seen === 1'b1)
            k = 1;
         else if (k > 0)
            k++;
         if (dq_oe_n === 1'b0) begin
            if (nb == 0)
               check(k, (lt == 0 ? 1 : lt) + 2);
            e = exp_beat(op, sd, nb);
            if (full)
               check({14'h0, rd_beat_out}, {14'h0, e});
            else
               check({16'h0, rd_beat_out.dq}, {16'h0, e.dq});
            check(dmi_oe_n, !full);
            nb++;
         end
      end
      check(nb, (op inside {mtf_pkg::OPC_RD_FIFO, mtf_pkg::OPC_CAL_RD} && !bd) ? 16 : 0);
      check(dq_oe_n, 1'b1);
   endtask

   task automatic stat(input logic [31:0] exp);
      apb(1'b0, mtf_pkg::REG_STAT, 32'h0);
      check(rdv, exp);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cke = 1'b1;
      pd_entry = 1'b0;
      go = 1'b0;
      bad = 1'b0;
      opcode = 7'h00;
      seed = 16'h0;
      lat = 6'h00;
      dmi_on = 1'b0;
      p0 = mtf_pkg::FIRST_PAT_RST;
      p1 = mtf_pkg::SECOND_PAT_RST;
      m0 = mtf_pkg::MASK_RST;
      m1 = mtf_pkg::MASK_RST;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, rows[i].a, 32'h0);
         check(rdv, rows[i].d);
         check(rerr, rows[i].e);
         check(pready, 1'b1);
      end
      run(mtf_pkg::OPC_CAL_RD, 16'h0, 6, 1'b0);
      p0 = 8'h1c;
      p1 = 8'h59;
      m1 = 8'ha3;
      apb(1'b1, mtf_pkg::REG_PATTERN, 32'h591c);
      apb(1'b1, mtf_pkg::REG_INVERT, 32'ha355);
      // Read inversion on, burst length field nonzero, masking enabled
      apb(1'b1, mtf_pkg::REG_MODE, 32'h41);
      apb(1'b1, mtf_pkg::REG_LAT, 32'h0203);
      run(mtf_pkg::OPC_CAL_RD, 16'h0, 3, 1'b0);
      for (int i = 0; i < 6; i++)
         run(mtf_pkg::OPC_WR_FIFO, 16'(i * 16'h1111), 2, 1'b0);
      stat(32'h001);
      dmi_on = 1'b1;
      for (int i = 0; i < 6; i++)
         run(mtf_pkg::OPC_RD_FIFO, 16'((i % 5 == 0 ? 5 : i % 5) * 16'h1111), 3, 1'b0);
      apb(1'b1, mtf_pkg::REG_MODE, 32'h80);
      dmi_on = 1'b0;
      run(mtf_pkg::OPC_RD_FIFO, 16'h1111, 3, 1'b0);
      stat(32'h021);
      @(posedge pclk);
      pd_entry <= 1'b1;
      @(posedge pclk);
      pd_entry <= 1'b0;
      stat(32'h0);
      for (int i = 0; i < 5; i++) begin
         run(codes[i], 16'h0, 1, 1'b0);
         stat(32'h0);
      end
      run(mtf_pkg::OPC_OSC_ON, 16'h0, 1, 1'b0);
      check(osc_run, 1'b1);
      stat(32'h100);
      run(mtf_pkg::OPC_OSC_OFF, 16'h0, 1, 1'b0);
      check(osc_run, 1'b0);
      // Clock enable low: the command must be ignored
      cke <= 1'b0;
      run(mtf_pkg::OPC_OSC_ON, 16'h0, 1, 1'b0);
      check(osc_run, 1'b0);
      cke <= 1'b1;
      run(mtf_pkg::OPC_ZQ_BEGIN, 16'h0, 1, 1'b0);
      check(zq_b, 1);
      check(zq_a, 0);
      run(mtf_pkg::OPC_ZQ_APPLY, 16'h0, 1, 1'b0);
      check(zq_a, 1);
      run(mtf_pkg::OPC_WR_FIFO, 16'h0, 2, 1'b1);
      stat(32'h400);
      apb(1'b1, mtf_pkg::REG_STAT, 32'h400);
      stat(32'h0);
      run(mtf_pkg::OPC_WR_FIFO, 16'h0, 2, 1'b0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      stat(32'h0);
      apb(1'b0, mtf_pkg::REG_PATTERN, 32'h0);
      check(rdv, rows[0].d);
      print_verdict();
   end
endmodule
